// [hw/reactive_energy_consts.vh]
// Constants shared by the reactive energy accumulator and its helper modules.
`ifndef REACTIVE_ENERGY_CONSTS_VH
`define REACTIVE_ENERGY_CONSTS_VH

// Register offsets on the special function register port.
`define OFS_REACTIVE_ENERGY 8'h04
`define OFS_REACTIVE_ENERGY_READ_RESET 8'h08
`define OFS_WAVEFORM_SELECT 8'h0D
`define OFS_NOLOAD_CONFIG 8'h0E
`define OFS_ACCUMULATION_CONFIG 8'h0F
`define OFS_REACTIVE_GAIN 8'h1E
`define OFS_REACTIVE_DIVIDER 8'h25
`define OFS_IRQ_ENABLE_ONE 8'hD9
`define OFS_IRQ_ENABLE_TWO 8'hDA
`define OFS_IRQ_ENABLE_THREE 8'hDB
`define OFS_IRQ_STATUS_ONE 8'hDC
`define OFS_IRQ_STATUS_TWO 8'hDD

// Field positions.
`define BIT_ACTIVE_SIGN_STEERED 2
`define BIT_ABSOLUTE_REACTIVE 3
`define BIT_SIGN_POLARITY 5
`define BIT_NOLOAD_FLAG 1
`define BIT_SIGN_CHANGE_FLAG 4
`define BIT_HALF_FULL_FLAG 1
`define BIT_OVERFLOW_FLAG 2
`define BIT_WAVEFORM_SAMPLE_ENABLE 5
`define NOLOAD_LEVEL_HI 3
`define NOLOAD_LEVEL_LO 2
`define WAVE_SOURCE_HI 4
`define WAVE_SOURCE_LO 2
`define WAVE_SOURCE_REACTIVE 3'h3
`define WAVE_RATE_HI 1
`define WAVE_RATE_LO 0

// Reset values of the writable registers.
`define RST_BYTE 8'h00
`define RST_GAIN 12'h000

// No-load thresholds on a 24-bit power word, full scale 2^23.
`define NOLOAD_THRESH_LEVEL1 24'h0004EA
`define NOLOAD_THRESH_LEVEL2 24'h000275
`define NOLOAD_THRESH_LEVEL3 24'h000136

// Accumulation cadence in master clock cycles.
`define ACC_TICK_CYCLES 3'h5
`define ACC_TICK_LAST 3'h4

// Waveform base rate and the clock it is derived from.
`define CLOCK_HZ 125000000
`define WAVE_BASE_RATE_HZ 25600
`define WAVE_BASE_CYCLES (`CLOCK_HZ / `WAVE_BASE_RATE_HZ)

`endif

// [hw/reactive_gain_divide.v]
// Gain scaling and energy divider stage of the reactive power path.
`timescale 1ns/100ps
`include "reactive_energy_consts.vh"

module reactive_gain_divide (
  input wire ref_clk_i, // Master clock.
  input wire reset_i, // Synchronous reset, active high.
  input wire signed [23:0] power_i, // Filtered reactive power.
  input wire [11:0] gain_i, // Signed gain trim.
  input wire [7:0] divider_i, // Unsigned energy divider.
  output reg signed [23:0] power_o // Scaled and divided power.
);

  wire signed [13:0] gain_s;
  wire signed [37:0] scaled;
  wire signed [24:0] trimmed;
  wire [24:0] magnitude;
  wire [7:0] div_eff;
  wire [24:0] quotient;
  wire [24:0] result;

  // Gain is one plus a signed twelve-bit fraction of 4096; 14 bits keep unity positive.
  assign gain_s = 14'sh1000 + $signed({{2{gain_i[11]}}, gain_i});
  assign scaled = power_i * gain_s;
  assign trimmed = scaled[36:12];
  // Division acts on the magnitude so rounding is symmetric about zero.
  assign magnitude = trimmed[24] ? (25'h0 - trimmed) : trimmed;
  assign div_eff = (divider_i == 8'h00) ? 8'h01 : divider_i;
  assign quotient = magnitude / {17'h0, div_eff};
  assign result = trimmed[24] ? (25'h0 - quotient) : quotient;

  // The word is registered; a gain above unity may clip, so saturate.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      power_o <= 24'h000000;
    end else if (result[24] != result[23]) begin
      power_o <= result[24] ? 24'h800000 : 24'h7FFFFF;
    end else begin
      power_o <= result[23:0];
    end
  end

endmodule

// [hw/waveform_sampler.v]
// Waveform sample strobe generator for the reactive power word.
`timescale 1ns/100ps
`include "reactive_energy_consts.vh"

module waveform_sampler #(
  parameter BASE_CYCLES = `WAVE_BASE_CYCLES // Cycles per sample at the fastest rate.
) (
  input wire ref_clk_i, // Master clock.
  input wire reset_i, // Synchronous reset, active high.
  input wire enable_i, // Sampling enabled and source selected.
  input wire [1:0] rate_i, // 0 fastest, each step halves the rate.
  input wire signed [23:0] power_i, // Word to sample.
  output reg [23:0] wave_data_o, // Latest sample.
  output reg wave_valid_o // One-cycle pulse per sample.
);

  reg [15:0] count_q;
  wire [15:0] period;

  // Slower rates stretch the base period by powers of two.
  assign period = BASE_CYCLES[15:0] << rate_i;

  // A disabled sampler restarts its period so the first sample is a full one.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      count_q <= 16'h0000;
      wave_data_o <= 24'h000000;
      wave_valid_o <= 1'b0;
    end else begin
      wave_valid_o <= 1'b0;
      if (!enable_i) begin
        count_q <= 16'h0000;
      end else if (count_q >= period - 16'h0001) begin
        count_q <= 16'h0000;
        wave_data_o <= power_i;
        wave_valid_o <= 1'b1;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

endmodule

// [hw/reactive_energy_accumulator.v]
// Reactive power sign, no-load detection and energy accumulation datapath.
`timescale 1ns/100ps
`include "reactive_energy_consts.vh"

// Contract
// - Reactive power sign follows phase angle sign.
// - Integrator on shifts -90, off shifts +90.
// - Polarity clear: flag on positive-to-negative change.
// - Polarity set: flag on negative-to-positive change.
// - Enabled sign flag holds interrupt until cleared.
// - Below no-load threshold: no accumulation, flag set.
// - Enabled no-load flag holds interrupt until cleared.
// - Level field selects off or three thresholds.
// - 49-bit accumulator, upper 24 bits readable.
// - One sample added every five clocks.
// - Default signed; absolute wins over steered mode.
// - Steered mode negates when active power negative.
// - Absolute mode accumulates reactive power magnitude.
// - Divide by divider; zero means one.
// - Read-reset returns energy, clears upper bits.
// - Energy wraps around at both full scales.
// - Half-full and overflow raise enabled interrupt.
// - Enabled waveform mode presents samples at rate.
// - Scale power by one plus gain/4096.
module reactive_energy_accumulator #(
  parameter WAVE_BASE_CYCLES = `WAVE_BASE_CYCLES, // Clocks per sample at the fastest rate.
  parameter ACC_W = 49 // Internal accumulator width.
) (
  input wire ref_clk_i, // Master clock.
  input wire reset_i, // Synchronous reset, active high.
  input wire sample_valid_i, // New voltage and current pair.
  input wire signed [15:0] voltage_i, // Voltage channel sample.
  input wire signed [15:0] current_quad_i, // Current after the quadrature filter.
  input wire integrator_on_i, // Current channel integrator enabled.
  input wire active_power_neg_i, // Active power is negative.
  input wire [7:0] sfr_addr_i, // Register offset.
  input wire [23:0] sfr_wdata_i, // Write data, low bits used.
  input wire sfr_wr_i, // Write strobe.
  input wire sfr_rd_i, // Read strobe.
  output reg [23:0] sfr_rdata_o, // Read data, one cycle after the strobe.
  output wire irq_o, // Metering interrupt pending.
  output wire [23:0] wave_data_o, // Waveform sample.
  output wire wave_valid_o // Waveform sample strobe.
);

  // Writable configuration registers.
  reg [7:0] waveform_select_q;
  reg [7:0] noload_config_q;
  reg [7:0] accumulation_config_q;
  reg [11:0] reactive_gain_q;
  reg [7:0] reactive_divider_q;
  reg [7:0] irq_enable_one_q;
  reg [7:0] irq_enable_two_q;
  reg [7:0] irq_enable_three_q;
  reg [7:0] irq_status_one_q;
  reg [7:0] irq_status_one_d;
  reg [7:0] irq_status_two_q;
  reg [7:0] irq_status_two_d;

  // Datapath state.
  reg signed [23:0] inst_q;
  reg signed [23:0] lpf_q;
  reg [ACC_W-1:0] acc_q;
  reg [ACC_W-1:0] acc_d;
  reg [2:0] tick_cnt_q;
  reg prev_neg_q;
  reg half_q;

  wire signed [31:0] product;
  wire signed [23:0] prod_word;
  wire signed [24:0] lpf_diff;
  wire signed [24:0] lpf_step;
  wire signed [23:0] power;
  wire tick;
  wire wr_hit;
  wire rr_read;
  wire abs_mode;
  wire steer_mode;
  wire polarity;
  wire [1:0] noload_level;
  wire [23:0] power_mag;
  wire [23:0] noload_thresh;
  wire noload;
  reg signed [24:0] delta;
  wire [ACC_W-1:0] delta_ext;
  wire [ACC_W-1:0] acc_sum;
  wire [23:0] energy;
  wire [23:0] energy_next;
  wire sign_event;
  wire half_now;
  wire wrap_event;
  wire wave_enable;

  // Threshold chosen by the no-load level field; zero turns detection off.
  function [23:0] noload_threshold;
    input [1:0] level;
    begin
      case (level)
        2'h1: noload_threshold = `NOLOAD_THRESH_LEVEL1;
        2'h2: noload_threshold = `NOLOAD_THRESH_LEVEL2;
        2'h3: noload_threshold = `NOLOAD_THRESH_LEVEL3;
        default: noload_threshold = 24'h000000;
      endcase
    end
  endfunction

  // Offset decode shared by the write and read paths.
  function is_offset;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_offset = (addr == ofs);
    end
  endfunction

  // The quadrature filter leads by 90 degrees with the integrator off and
  // lags by 90 with it on; flipping the product in the second case keeps
  // the sign tied to the phase angle either way.
  assign product = voltage_i * current_quad_i;
  assign prod_word = product[30:7];

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      inst_q <= 24'h000000;
    end else if (sample_valid_i) begin
      inst_q <= integrator_on_i ? (24'h000000 - prod_word) : prod_word;
    end
  end

  // Low-pass filter keeps the DC part, which is the signed reactive power.
  // The double-frequency ripple is left small and averages out in energy.
  assign lpf_diff = {inst_q[23], inst_q} - {lpf_q[23], lpf_q};
  assign lpf_step = lpf_diff >>> 4;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      lpf_q <= 24'h000000;
    end else if (sample_valid_i) begin
      lpf_q <= lpf_q + lpf_step[23:0];
    end
  end

  // Gain trim and divider sit in their own registered stage.
  reactive_gain_divide u_gain_divide (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .power_i(lpf_q),
    .gain_i(reactive_gain_q),
    .divider_i(reactive_divider_q),
    .power_o(power)
  );

  // Accumulation cadence: one addition every five master clocks.
  assign tick = (tick_cnt_q == `ACC_TICK_LAST);

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      tick_cnt_q <= 3'h0;
    end else if (tick) begin
      tick_cnt_q <= 3'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
    end
  end

  // Mode and no-load decoding.
  assign abs_mode = accumulation_config_q[`BIT_ABSOLUTE_REACTIVE];
  assign steer_mode = accumulation_config_q[`BIT_ACTIVE_SIGN_STEERED];
  assign polarity = accumulation_config_q[`BIT_SIGN_POLARITY];
  assign noload_level = noload_config_q[`NOLOAD_LEVEL_HI:`NOLOAD_LEVEL_LO];
  assign power_mag = power[23] ? (24'h000000 - power) : power;
  assign noload_thresh = noload_threshold(noload_level);
  assign noload = (noload_level != 2'h0) && (power_mag < noload_thresh);

  // Amount added per tick; absolute mode is checked first so it wins.
  // The word is one bit wider so negating full-scale negative is exact.
  always @* begin
    if (abs_mode) begin
      delta = {1'b0, power_mag};
    end else if (steer_mode && active_power_neg_i) begin
      delta = 25'h0000000 - {power[23], power};
    end else begin
      delta = {power[23], power};
    end
  end

  assign delta_ext = {{(ACC_W-25){delta[24]}}, delta};
  assign acc_sum = acc_q + delta_ext;
  assign energy = acc_q[ACC_W-1:ACC_W-24];
  assign rr_read = sfr_rd_i && is_offset(sfr_addr_i, `OFS_REACTIVE_ENERGY_READ_RESET);

  // Accumulator update; a read-reset in a tick cycle still keeps the new
  // sample, only the upper 24 bits are zeroed.
  always @* begin
    acc_d = acc_q;
    if (tick && !noload) begin
      acc_d = acc_sum;
    end
    if (rr_read) begin
      acc_d = {24'h000000, acc_d[ACC_W-25:0]};
    end
  end

  // Two's complement addition wraps at both full scales by itself.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_q <= {ACC_W{1'b0}};
    end else begin
      acc_q <= acc_d;
    end
  end

  // Wrap and half-full events from the readable upper bits.
  assign energy_next = acc_sum[ACC_W-1:ACC_W-24];
  assign wrap_event = tick && !noload &&
                      (energy[23] != energy_next[23]) &&
                      (energy_next[23] != delta[24]);
  assign half_now = energy[23] ^ energy[22];

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= half_now;
    end
  end

  // Sign tracking; zero is treated as positive.
  assign sign_event = tick &&
                      (polarity ? (prev_neg_q && !power[23])
                                : (!prev_neg_q && power[23]));

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      prev_neg_q <= 1'b0;
    end else if (tick) begin
      prev_neg_q <= power[23];
    end
  end

  // Status flags: a write of zero clears a bit, and an event in the same
  // cycle sets it again so nothing is lost.
  assign wr_hit = sfr_wr_i;

  always @* begin
    irq_status_one_d = irq_status_one_q;
    irq_status_two_d = irq_status_two_q;
    if (wr_hit && is_offset(sfr_addr_i, `OFS_IRQ_STATUS_ONE)) begin
      irq_status_one_d = irq_status_one_q & sfr_wdata_i[7:0];
    end
    if (wr_hit && is_offset(sfr_addr_i, `OFS_IRQ_STATUS_TWO)) begin
      irq_status_two_d = irq_status_two_q & sfr_wdata_i[7:0];
    end
    if (noload) begin
      irq_status_one_d[`BIT_NOLOAD_FLAG] = 1'b1;
    end
    if (sign_event) begin
      irq_status_one_d[`BIT_SIGN_CHANGE_FLAG] = 1'b1;
    end
    if (half_now && !half_q) begin
      irq_status_two_d[`BIT_HALF_FULL_FLAG] = 1'b1;
    end
    if (wrap_event) begin
      irq_status_two_d[`BIT_OVERFLOW_FLAG] = 1'b1;
    end
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_status_one_q <= `RST_BYTE;
      irq_status_two_q <= `RST_BYTE;
    end else begin
      irq_status_one_q <= irq_status_one_d;
      irq_status_two_q <= irq_status_two_d;
    end
  end

  // Interrupt stays pending while any enabled flag remains set.
  assign irq_o = |(irq_status_one_q & irq_enable_one_q) |
                 |(irq_status_two_q & irq_enable_two_q);

  // Configuration writes.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      waveform_select_q <= `RST_BYTE;
      noload_config_q <= `RST_BYTE;
      accumulation_config_q <= `RST_BYTE;
      reactive_gain_q <= `RST_GAIN;
      reactive_divider_q <= `RST_BYTE;
      irq_enable_one_q <= `RST_BYTE;
      irq_enable_two_q <= `RST_BYTE;
      irq_enable_three_q <= `RST_BYTE;
    end else if (wr_hit) begin
      if (is_offset(sfr_addr_i, `OFS_WAVEFORM_SELECT)) begin
        waveform_select_q <= sfr_wdata_i[7:0];
      end
      if (is_offset(sfr_addr_i, `OFS_NOLOAD_CONFIG)) begin
        noload_config_q <= sfr_wdata_i[7:0];
      end
      if (is_offset(sfr_addr_i, `OFS_ACCUMULATION_CONFIG)) begin
        accumulation_config_q <= sfr_wdata_i[7:0];
      end
      if (is_offset(sfr_addr_i, `OFS_REACTIVE_GAIN)) begin
        reactive_gain_q <= sfr_wdata_i[11:0];
      end
      if (is_offset(sfr_addr_i, `OFS_REACTIVE_DIVIDER)) begin
        reactive_divider_q <= sfr_wdata_i[7:0];
      end
      if (is_offset(sfr_addr_i, `OFS_IRQ_ENABLE_ONE)) begin
        irq_enable_one_q <= sfr_wdata_i[7:0];
      end
      if (is_offset(sfr_addr_i, `OFS_IRQ_ENABLE_TWO)) begin
        irq_enable_two_q <= sfr_wdata_i[7:0];
      end
      if (is_offset(sfr_addr_i, `OFS_IRQ_ENABLE_THREE)) begin
        irq_enable_three_q <= sfr_wdata_i[7:0];
      end
    end
  end

  // Read path: registered, unmapped offsets read as zero.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 24'h000000;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `OFS_REACTIVE_ENERGY: sfr_rdata_o <= energy;
        `OFS_REACTIVE_ENERGY_READ_RESET: sfr_rdata_o <= energy;
        `OFS_WAVEFORM_SELECT: sfr_rdata_o <= {16'h0000, waveform_select_q};
        `OFS_NOLOAD_CONFIG: sfr_rdata_o <= {16'h0000, noload_config_q};
        `OFS_ACCUMULATION_CONFIG: sfr_rdata_o <= {16'h0000, accumulation_config_q};
        `OFS_REACTIVE_GAIN: sfr_rdata_o <= {12'h000, reactive_gain_q};
        `OFS_REACTIVE_DIVIDER: sfr_rdata_o <= {16'h0000, reactive_divider_q};
        `OFS_IRQ_ENABLE_ONE: sfr_rdata_o <= {16'h0000, irq_enable_one_q};
        `OFS_IRQ_ENABLE_TWO: sfr_rdata_o <= {16'h0000, irq_enable_two_q};
        `OFS_IRQ_ENABLE_THREE: sfr_rdata_o <= {16'h0000, irq_enable_three_q};
        `OFS_IRQ_STATUS_ONE: sfr_rdata_o <= {16'h0000, irq_status_one_q};
        `OFS_IRQ_STATUS_TWO: sfr_rdata_o <= {16'h0000, irq_status_two_q};
        default: sfr_rdata_o <= 24'h000000;
      endcase
    end
  end

  // Waveform output only runs with reactive power selected and sampling on.
  assign wave_enable = irq_enable_three_q[`BIT_WAVEFORM_SAMPLE_ENABLE] &&
                       (waveform_select_q[`WAVE_SOURCE_HI:`WAVE_SOURCE_LO] ==
                        `WAVE_SOURCE_REACTIVE);

  waveform_sampler #(
    .BASE_CYCLES(WAVE_BASE_CYCLES)
  ) u_waveform_sampler (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .enable_i(wave_enable),
    .rate_i(waveform_select_q[`WAVE_RATE_HI:`WAVE_RATE_LO]),
    .power_i(power),
    .wave_data_o(wave_data_o),
    .wave_valid_o(wave_valid_o)
  );

endmodule

// [tb/reactive_energy_accumulator_sva.sv]
// Port-level assertion checker for the reactive energy accumulator.
`timescale 1ns/100ps
module reactive_energy_accumulator_sva #(
  parameter WAVE_BASE_CYCLES = 8, // Clocks per sample at the fastest rate.
  parameter ACC_W = 49 // Internal accumulator width.
) (
  input wire ref_clk_i, // Master clock.
  input wire reset_i, // Synchronous reset, active high.
  input wire [7:0] sfr_addr_i, // Register offset.
  input wire [23:0] sfr_wdata_i, // Write data.
  input wire sfr_wr_i, // Write strobe.
  input wire sfr_rd_i, // Read strobe.
  input wire [23:0] sfr_rdata_o, // Read data.
  input wire irq_o, // Interrupt pending.
  input wire [23:0] wave_data_o, // Waveform sample.
  input wire wave_valid_o // Waveform strobe.
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Register port reads and writes of interest.
  wire rd_clr = sfr_rd_i && sfr_addr_i == 8'h08;
  wire rd_nrg = sfr_rd_i && sfr_addr_i == 8'h04;
  wire wr_en1 = sfr_wr_i && sfr_addr_i == 8'hD9 && sfr_wdata_i[7:0] == 8'h00;
  wire wr_en2 = sfr_wr_i && sfr_addr_i == 8'hDA && sfr_wdata_i[7:0] == 8'h00;

  // Nothing may be pending or pulsing right out of reset.
  a_reset_exit_quiet: assert property ($fell(reset_i) |-> !irq_o && !wave_valid_o)
    else $error("output active right after reset");
  // Waveform strobe is a lone pulse, at least one base period apart.
  a_wave_pulse_gap: assert property (wave_valid_o |=> !wave_valid_o [*7])
    else $error("waveform strobes too close");
  a_wave_data_hold: assert property (!wave_valid_o |-> $stable(wave_data_o))
    else $error("waveform word moved without strobe");
  // Read data only moves on the cycle after a read.
  a_rdata_hold: assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    sfr_rd_i && sfr_addr_i == 8'h00 |=> sfr_rdata_o == 24'h000000)
    else $error("unmapped read not zero");
  // A read-reset leaves at most one tick of energy in the upper bits.
  a_clear_on_read: assert property (
    rd_clr ##2 rd_nrg |=> sfr_rdata_o inside {24'h000000, 24'h000001, 24'hFFFFFF})
    else $error("energy not cleared by read-reset");
  // With interrupt enables one and two cleared the interrupt must drop.
  a_irq_all_off: assert property (wr_en1 ##2 wr_en2 |=> !irq_o)
    else $error("interrupt pending with enables off");
  a_byte_reg_width: assert property (
    sfr_rd_i && (sfr_addr_i == 8'h0E || sfr_addr_i == 8'h0F) |=> sfr_rdata_o[23:8] == 16'h0000)
    else $error("byte register reads wide");
  a_gain_width: assert property (
    sfr_rd_i && sfr_addr_i == 8'h1E |=> sfr_rdata_o[23:12] == 12'h000)
    else $error("gain register reads wide");
  // Main scenarios reached.
  c_read_reset: cover property (rd_clr ##2 rd_nrg);
  c_wave: cover property (wave_valid_o);
  c_irq: cover property ($rose(irq_o));
endmodule

bind reactive_energy_accumulator reactive_energy_accumulator_sva #(
  .WAVE_BASE_CYCLES(WAVE_BASE_CYCLES),
  .ACC_W(ACC_W)
) checker_i (
  .ref_clk_i(ref_clk_i),
  .reset_i(reset_i),
  .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i),
  .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o),
  .irq_o(irq_o),
  .wave_data_o(wave_data_o),
  .wave_valid_o(wave_valid_o)
);

// [tb/sfr_core.sv]
// Model of the core that reads and writes the block's registers.
`timescale 1ns/100ps
module sfr_core (
  input wire ref_clk_i, // Master clock.
  input wire [23:0] sfr_rdata_i, // Read data from the block.
  output reg [7:0] sfr_addr_o, // Register offset.
  output reg [23:0] sfr_wdata_o, // Write data.
  output reg sfr_wr_o, // Write strobe.
  output reg sfr_rd_o // Read strobe.
);
  // Idle port at time zero.
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 24'h000000;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
  end
  // Write held over the taking edge; the idle bus then shows inverted values
  // so that a stale copy can never pass for a real request.
  task wr(input [7:0] a, input [23:0] v);
    begin
      @(posedge ref_clk_i);
      sfr_addr_o <= a;
      sfr_wdata_o <= v;
      sfr_wr_o <= 1'b1;
      @(posedge ref_clk_i);
      sfr_wr_o <= 1'b0;
      sfr_addr_o <= ~a;
      sfr_wdata_o <= ~v;
    end
  endtask
  // Read: the answer stands in the cycle after the taking edge.
  task rd(input [7:0] a, output [23:0] v);
    begin
      @(posedge ref_clk_i);
      sfr_addr_o <= a;
      sfr_rd_o <= 1'b1;
      @(posedge ref_clk_i);
      sfr_rd_o <= 1'b0;
      sfr_addr_o <= ~a;
      #1;
      v = sfr_rdata_i;
    end
  endtask
endmodule

// [tb/reactive_energy_accumulator_test.sv]
// Self-checking testbench for the reactive energy accumulator.
`timescale 1ns/100ps
module reactive_energy_accumulator_test;
  localparam [63:0] RW_OFS = 64'h0D0E0F1E25D9DADB;
  localparam [71:0] GAINS = 72'h000000000000400C00;
  localparam [47:0] DIVS = 48'h000102040000;
  localparam [47:0] STEPS = 48'h14140A05190F;
  localparam [6:0] INTEG = 7'b0111011;
  localparam [6:0] ANEG = 7'b0001101;
  localparam [6:0] NEG = 7'b0110100;
  localparam [55:0] CFG = 56'h0000040404080C;
  reg ref_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg sample_valid_i = 1'b0;
  reg [15:0] voltage_i = 16'h0000;
  reg [15:0] current_quad_i = 16'h0000;
  reg integrator_on_i = 1'b0;
  reg active_power_neg_i = 1'b0;
  wire [7:0] sfr_addr_i;
  wire [23:0] sfr_wdata_i;
  wire sfr_wr_i;
  wire sfr_rd_i;
  wire [23:0] sfr_rdata_o;
  wire irq_o;
  wire [23:0] wave_data_o;
  wire wave_valid_o;
  integer n_errors = 0;
  integer tests_run = 0;
  integer i;
  integer n;
  reg [23:0] d;
  reg [23:0] e;

  // Master clock, 8 ns period.
  always #4 ref_clk_i = ~ref_clk_i;

  reactive_energy_accumulator #(.WAVE_BASE_CYCLES(8)) reactive_energy_accumulator_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sample_valid_i(sample_valid_i),
    .voltage_i(voltage_i), .current_quad_i(current_quad_i),
    .integrator_on_i(integrator_on_i), .active_power_neg_i(active_power_neg_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o),
    .wave_data_o(wave_data_o), .wave_valid_o(wave_valid_o));

  sfr_core sfr_core_i (
    .ref_clk_i(ref_clk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
    .sfr_wdata_o(sfr_wdata_i), .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i));

  // Verdict and end of run.
  task end_sim;
    begin
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  // Compare within a tolerance; the filter settles a few counts short.
  task chk(input [8*12-1:0] nm, input [23:0] ex, input [23:0] got, input integer tol);
    reg signed [23:0] diff;
    begin
      diff = got - ex;
      tests_run = tests_run + 1;
      if (got !== ex && (^got === 1'bx || diff > tol || diff < -tol)) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s: expected %h, seen %h", nm, ex, got);
      end
    end
  endtask

  task cyc(input integer k);
    begin
      repeat (k) @(posedge ref_clk_i);
    end
  endtask

  task chkreg(input [8*12-1:0] nm, input [7:0] a, input [23:0] ex, input integer tol);
    begin
      sfr_core_i.rd(a, d);
      chk(nm, ex, d, tol);
    end
  endtask

  task chkbit(input [8*12-1:0] nm, input [7:0] a, input integer b, input ex);
    begin
      sfr_core_i.rd(a, d);
      chk(nm, {23'h0, ex}, {23'h0, d[b]}, 0);
    end
  endtask

  // Interrupt is combinational, so look once the write has landed.
  task chkirq(input ex);
    begin
      #1;
      chk("irq", {23'h0, ex}, {23'h0, irq_o}, 0);
    end
  endtask

  // New sample inputs, then time for the low-pass filter to settle.
  task setin(input [15:0] v, input [15:0] c, input g, input an);
    begin
      @(posedge ref_clk_i);
      voltage_i <= v;
      current_quad_i <= c;
      integrator_on_i <= g;
      active_power_neg_i <= an;
      sample_valid_i <= 1'b1;
      cyc(400);
    end
  endtask

  // Energy change over 1600 clocks, i.e. 320 accumulation ticks.
  task meas(input integer ex);
    begin
      sfr_core_i.rd(8'h04, d);
      cyc(1598);
      sfr_core_i.rd(8'h04, e);
      chk("energy step", ex, e - d, 1);
    end
  endtask

  // Next waveform strobe, counting the clocks taken.
  task wv;
    begin
      n = 1;
      @(posedge ref_clk_i);
      #1;
      while (wave_valid_o !== 1'b1) begin
        @(posedge ref_clk_i);
        #1;
        n = n + 1;
        if (n > 300) begin
          n_errors = n_errors + 1;
          $display("wrong value wave strobe: expected 1, seen 0");
          end_sim;
        end
      end
    end
  endtask

  initial begin
    cyc(16);
    reset_i <= 1'b0;
    // Register map, reset values, widths and read-only energy.
    chkreg("unmapped", 8'h00, 24'h0, 0);
    sfr_core_i.wr(8'h04, 24'h123456);
    chkreg("energy", 8'h04, 24'h0, 0);
    for (i = 0; i < 8; i = i + 1) begin
      chkreg("reset value", RW_OFS[63-8*i -: 8], 24'h0, 0);
      sfr_core_i.wr(RW_OFS[63-8*i -: 8], 24'hFFFFFF);
      chkreg("write back", RW_OFS[63-8*i -: 8], (i == 3) ? 24'hFFF : 24'hFF, 0);
      sfr_core_i.wr(RW_OFS[63-8*i -: 8], 24'h0);
    end
    // No-load flag with zero power, its interrupt, holding and clearing.
    sfr_core_i.wr(8'hDC, 24'h0);
    sfr_core_i.wr(8'hD9, 24'h02);
    sfr_core_i.wr(8'h0E, 24'h04);
    chkbit("noload flag", 8'hDC, 1, 1'b1);
    chkirq(1'b1);
    sfr_core_i.wr(8'h0E, 24'h00);
    sfr_core_i.wr(8'hDC, 24'hFF);
    chkbit("noload flag", 8'hDC, 1, 1'b1);
    chkirq(1'b1);
    sfr_core_i.wr(8'hDC, 24'h00);
    chkirq(1'b0);
    chkbit("noload flag", 8'hDC, 1, 1'b0);
    // Threshold per level at two power values between the thresholds.
    for (i = 0; i < 6; i = i + 1) begin
      if (i == 0 || i == 3) setin((i == 0) ? 16'h0100 : 16'h0180, 16'h0100, 1'b0, 1'b0);
      sfr_core_i.wr(8'h0E, ((i % 3) + 1) << 2);
      sfr_core_i.wr(8'hDC, 24'h0);
      cyc(4);
      chkbit("noload level", 8'hDC, 1, 6'b110100 >> (5 - i));
    end
    sfr_core_i.wr(8'h0E, 24'h0);
    sfr_core_i.wr(8'hDC, 24'h0);
    // Gain and divider, power word 2^21 gives 20 counts per 1600 clocks.
    setin(16'h4000, 16'h4000, 1'b0, 1'b0);
    for (i = 0; i < 6; i = i + 1) begin
      sfr_core_i.wr(8'h1E, GAINS[71-12*i -: 12]);
      sfr_core_i.wr(8'h25, DIVS[47-8*i -: 8]);
      cyc(8);
      meas(STEPS[47-8*i -: 8]);
    end
    sfr_core_i.wr(8'h1E, 24'h0);
    sfr_core_i.wr(8'h25, 24'h0);
    // Sign, steered and absolute accumulation modes.
    for (i = 0; i < 7; i = i + 1) begin
      sfr_core_i.wr(8'h0F, CFG[55-8*i -: 8]);
      setin(16'h4000, 16'h4000, INTEG[6-i], ANEG[6-i]);
      meas(NEG[6-i] ? -20 : 20);
    end
    // Sign-change flag for both polarities and both directions.
    sfr_core_i.wr(8'hD9, 24'h10);
    for (i = 0; i < 4; i = i + 1) begin
      sfr_core_i.wr(8'h0F, (i >= 2) ? 24'h20 : 24'h00);
      setin(16'h4000, 16'h4000, i[0], 1'b0);
      sfr_core_i.wr(8'hDC, 24'h0);
      setin(16'h4000, 16'h4000, !i[0], 1'b0);
      chkbit("sign flag", 8'hDC, 4, (i == 0) || (i == 3));
      chkirq((i == 0) || (i == 3));
    end
    sfr_core_i.wr(8'hD9, 24'h0);
    sfr_core_i.wr(8'hDA, 24'h0);
    chkirq(1'b0);
    sfr_core_i.wr(8'h0F, 24'h0);
    // Read-reset returns the energy, then the upper bits are clear.
    meas(20);
    sfr_core_i.rd(8'h04, d);
    sfr_core_i.rd(8'h08, e);
    chk("read reset", d, e, 1);
    chkreg("energy", 8'h04, 24'h0, 1);
    // Waveform strobe period at each rate and the sampled word.
    sfr_core_i.wr(8'hDB, 24'h20);
    for (i = 0; i < 4; i = i + 1) begin
      sfr_core_i.wr(8'h0D, 24'h0C | i);
      wv;
      wv;
      chk("wave period", 8 << i, n, 0);
      chk("wave data", 24'h200000, wave_data_o, 16);
    end
    end_sim;
  end
endmodule
